// [include/aspbg_params.svh]
`ifndef ASPBG_PARAMS_SVH
`define ASPBG_PARAMS_SVH

// Timer clock source select codes
`define ASPBG_SRC_CORE      3'h0
`define ASPBG_SRC_DIV4      3'h1
`define ASPBG_SRC_DIV12     3'h2
`define ASPBG_SRC_DIV48     3'h3
`define ASPBG_SRC_EXTOSC8   3'h4
`define ASPBG_SRC_EXTPIN    3'h5

// Prescale divide figures, and the last count (7) of the divide-by-8 oscillator counter
`define ASPBG_DIV4          6'h04
`define ASPBG_DIV12         6'h0C
`define ASPBG_DIV48         6'h30
`define ASPBG_DIV_EXTOSC    3'h7

// Frame lengths in bit times, start and stop included
`define ASPBG_BITS8         4'hA
`define ASPBG_BITS9         4'hB

// Reset values
`define ASPBG_LINE_IDLE     1'h1
`define ASPBG_COUNT_RST     8'h00

`endif

// [include/aspbg_pkg.sv]
package aspbg_pkg;

    typedef enum logic [2:0] {
        ASPBG_TX_IDLE  = 3'b001,
        ASPBG_TX_SHIFT = 3'b010,
        ASPBG_TX_STOP  = 3'b100
    } aspbg_tx_e;

    typedef enum logic [2:0] {
        ASPBG_RX_IDLE  = 3'b001,
        ASPBG_RX_SHIFT = 3'b010,
        ASPBG_RX_DONE  = 3'b100
    } aspbg_rx_e;

    // Software-visible configuration of the port and its baud timer
    typedef struct packed {
        logic       nineBitMode;
        logic       multiprocEnable;
        logic       rxEnable;
        logic       ninthTxBit;
        logic       timerRun;
        logic [2:0] timerSource;
        logic [7:0] reloadValue;
    } aspbg_cfg_s;

    // Receive results and both done flags shown to software
    typedef struct packed {
        logic [7:0] rxData;
        logic       ninthRxBit;
        logic       txDoneFlag;
        logic       rxDoneFlag;
    } aspbg_status_s;

endpackage : aspbg_pkg

// [src/aspbg_sync.sv]
module aspbg_sync (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1  <= 1'b1;
            syncOut <= 1'b1;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : aspbg_sync

// [src/aspbg_baud_timer.sv]
`include "aspbg_params.svh"

// 8-bit auto-reload counter; overflow pulse for one cycle per wrap
module aspbg_baud_timer (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       tick,
    input  wire logic       forceReload,
    input  wire logic [7:0] reloadValue,
    output logic            overflow
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_overflow;

    always_comb begin
        next_count    = count;
        next_overflow = 1'b0;
        if (forceReload) begin
            next_count = reloadValue;
        end else if (tick) begin
            if (count == 8'hFF) begin
                next_count    = reloadValue;
                next_overflow = 1'b1;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count    <= `ASPBG_COUNT_RST;
            overflow <= 1'b0;
        end else begin
            count    <= next_count;
            overflow <= next_overflow;
        end
    end
endmodule : aspbg_baud_timer

// [src/aspbg_serial_port.sv]
`include "aspbg_params.svh"

//------------------------------------------------------------------
// Notes on behaviour
// - A finished byte sits in a receive buffer so the next can start.
// - A data write while the transmitter is idle loads the shifter and starts sending.
// - Data reads always show the receive buffer, never transmit data.
// - Interrupt requested while enabled and either done flag is set.
// - Done flags clear only by software clear strobes.
// - Transmit bit clock comes from overflows of the 8-bit timer.
// - Receive bit clock comes from a hidden copy of the timer.
// - Both overflow streams are divided by two to give the bit rate.
// - A start edge forces a reload of the receive timer copy.
// - Timer clock chosen from six sources.
// - Overflow rate is timer clock over 256 minus reload.
// - 8-bit frames: start, eight data LSB first, stop.
// - 9-bit frames add a ninth bit from and to the ninth bit fields.
// - Transmit-done is set at the start of the stop bit.
// - Byte loads only if rx-done is clear and, in multiproc, bit is 1.
//------------------------------------------------------------------
module aspbg_serial_port (
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    input  wire aspbg_pkg::aspbg_cfg_s  cfg,
    input  wire logic                   intEnable,
    input  wire logic                   dataWrite,
    input  wire logic [7:0]             dataWriteValue,
    input  wire logic                   txDoneClear,
    input  wire logic                   rxDoneClear,
    input  wire logic                   extOscClock,
    input  wire logic                   timerExternalInput,
    input  wire logic                   serialRxPin,
    output logic                        serialTxPin,
    output aspbg_pkg::aspbg_status_s    status,
    output logic                        irq
);
    //--------------------------------------------------------------
    // Timer clock source
    //--------------------------------------------------------------
    logic       rxSync;
    logic       extOscSync;
    logic       extPinSync;
    logic [5:0] preCount;
    logic [5:0] next_preCount;
    logic [2:0] oscCount;
    logic [2:0] next_oscCount;
    logic       extOscLast;
    logic       extPinLast;
    logic       timerTick;

    aspbg_sync uSyncRx (.clk_sys(clk_sys), .arst_n(arst_n),
                        .asyncIn(serialRxPin), .syncOut(rxSync));
    aspbg_sync uSyncOsc (.clk_sys(clk_sys), .arst_n(arst_n),
                         .asyncIn(extOscClock), .syncOut(extOscSync));
    aspbg_sync uSyncPin (.clk_sys(clk_sys), .arst_n(arst_n),
                         .asyncIn(timerExternalInput), .syncOut(extPinSync));
    function automatic logic preWrap(input logic [5:0] cnt,
                                     input logic [5:0] div);
        preWrap = (cnt >= div - 6'h01);
    endfunction : preWrap
    always_comb begin
        next_preCount = preWrap(preCount, `ASPBG_DIV48) ? 6'h00
                                                        : preCount + 6'h01;
        next_oscCount = oscCount;
        if (extOscSync && !extOscLast) begin
            next_oscCount = oscCount + 3'h1;
        end
        timerTick = 1'b0;
        unique case (cfg.timerSource)
            `ASPBG_SRC_CORE:    timerTick = 1'b1;
            `ASPBG_SRC_DIV4:    timerTick = (preCount[1:0] == 2'h3);
            `ASPBG_SRC_DIV12:   timerTick = (preCount % `ASPBG_DIV12 == 6'h0B);
            `ASPBG_SRC_DIV48:   timerTick = preWrap(preCount, `ASPBG_DIV48);
            `ASPBG_SRC_EXTOSC8: timerTick = extOscSync && !extOscLast &&
                                            (oscCount == `ASPBG_DIV_EXTOSC);
            `ASPBG_SRC_EXTPIN:  timerTick = extPinSync && !extPinLast;
            default:            timerTick = 1'b0;
        endcase
        timerTick = timerTick && cfg.timerRun;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            preCount   <= 6'h00;
            oscCount   <= 3'h0;
            // Same level as the synchroniser reset, so no false edge
            extOscLast <= 1'b1;
            extPinLast <= 1'b1;
        end else begin
            preCount   <= next_preCount;
            oscCount   <= next_oscCount;
            extOscLast <= extOscSync;
            extPinLast <= extPinSync;
        end
    end

    //--------------------------------------------------------------
    // Baud timers: visible transmit counter and hidden receive copy
    //--------------------------------------------------------------
    logic txOverflow;
    logic rxOverflow;
    logic rxStart;

    aspbg_baud_timer uTxTimer (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .tick       (timerTick),
        .forceReload(1'b0),
        .reloadValue(cfg.reloadValue),
        .overflow   (txOverflow)
    );
    aspbg_baud_timer uRxTimer (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .tick       (timerTick),
        .forceReload(rxStart),
        .reloadValue(cfg.reloadValue),
        .overflow   (rxOverflow)
    );

    //--------------------------------------------------------------
    // Transmitter
    //--------------------------------------------------------------
    aspbg_pkg::aspbg_tx_e txState;
    aspbg_pkg::aspbg_tx_e next_txState;
    logic [9:0] txShift;
    logic [9:0] next_txShift;
    logic [3:0] txBits;
    logic [3:0] next_txBits;
    logic       txHalf;
    logic       next_txHalf;
    logic       next_serialTxPin;
    logic       txDoneSet;
    logic       txBitTick;

    // Divide by two: every second overflow is a bit boundary
    assign txBitTick = txOverflow && txHalf;
    always_comb begin
        next_txState     = txState;
        next_txShift     = txShift;
        next_txBits      = txBits;
        next_txHalf      = txOverflow ? !txHalf : txHalf;
        next_serialTxPin = serialTxPin;
        txDoneSet        = 1'b0;
        unique case (txState)
            aspbg_pkg::ASPBG_TX_IDLE: begin
                if (dataWrite) begin
                    next_txShift = {`ASPBG_LINE_IDLE, cfg.ninthTxBit,
                                    dataWriteValue};
                    next_txBits  = cfg.nineBitMode ? 4'h9 : 4'h8;
                    next_txState = aspbg_pkg::ASPBG_TX_SHIFT;
                    next_serialTxPin = 1'b0;
                    next_txHalf  = 1'b0;
                end
            end
            aspbg_pkg::ASPBG_TX_SHIFT: begin
                if (txBitTick) begin
                    next_serialTxPin = txShift[0];
                    next_txShift     = {1'b1, txShift[9:1]};
                    next_txBits      = txBits - 4'h1;
                    if (txBits == 4'h0) begin
                        next_serialTxPin = 1'b1;
                        next_txState     = aspbg_pkg::ASPBG_TX_STOP;
                        txDoneSet        = 1'b1;
                    end
                end
            end
            aspbg_pkg::ASPBG_TX_STOP: begin
                if (txBitTick) begin
                    next_txState = aspbg_pkg::ASPBG_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            txState     <= aspbg_pkg::ASPBG_TX_IDLE;
            txShift     <= 10'h3FF;
            txBits      <= 4'h0;
            txHalf      <= 1'b0;
            serialTxPin <= `ASPBG_LINE_IDLE;
        end else begin
            txState     <= next_txState;
            txShift     <= next_txShift;
            txBits      <= next_txBits;
            txHalf      <= next_txHalf;
            serialTxPin <= next_serialTxPin;
        end
    end

    //--------------------------------------------------------------
    // Receiver
    //--------------------------------------------------------------
    aspbg_pkg::aspbg_rx_e rxState;
    aspbg_pkg::aspbg_rx_e next_rxState;
    logic [8:0] rxShift;
    logic [8:0] next_rxShift;
    logic [4:0] rxTicks;
    logic [4:0] next_rxTicks;
    logic       rxLast;
    logic       rxDoneSet;
    logic       rxLoadOk;
    logic [3:0] frameTicks;

    assign rxStart = (rxState == aspbg_pkg::ASPBG_RX_IDLE) &&
                     cfg.rxEnable && rxLast && !rxSync;
    assign frameTicks = cfg.nineBitMode ? `ASPBG_BITS9 : `ASPBG_BITS8;
    // Half-bit overflows: even nonzero rxTicks counts land mid-bit, where data is sampled
    always_comb begin
        next_rxState = rxState;
        next_rxShift = rxShift;
        next_rxTicks = rxTicks;
        rxDoneSet    = 1'b0;
        rxLoadOk     = 1'b0;
        unique case (rxState)
            aspbg_pkg::ASPBG_RX_IDLE: begin
                if (rxStart) begin
                    next_rxTicks = 5'h00;
                    next_rxState = aspbg_pkg::ASPBG_RX_SHIFT;
                end
            end
            aspbg_pkg::ASPBG_RX_SHIFT: begin
                if (rxOverflow) begin
                    next_rxTicks = rxTicks + 5'h01;
                    if (rxTicks == 5'h00 && rxSync) begin
                        next_rxState = aspbg_pkg::ASPBG_RX_IDLE;
                    end else if (rxTicks != 5'h00 && !rxTicks[0]) begin
                        // Nine bits kept; a 9-bit frame's stop is not
                        if (rxTicks[4:1] <= 4'h9) begin
                            next_rxShift = {rxSync, rxShift[8:1]};
                        end
                        if (rxTicks[4:1] == frameTicks - 4'h1) begin
                            next_rxState = aspbg_pkg::ASPBG_RX_DONE;
                        end
                    end
                end
            end
            aspbg_pkg::ASPBG_RX_DONE: begin
                rxLoadOk = !status.rxDoneFlag &&
                           (!cfg.multiprocEnable || rxShift[8]);
                rxDoneSet    = rxLoadOk;
                next_rxState = aspbg_pkg::ASPBG_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rxState <= aspbg_pkg::ASPBG_RX_IDLE;
            rxShift <= 9'h000;
            rxTicks <= 5'h00;
            rxLast  <= `ASPBG_LINE_IDLE;
        end else begin
            rxState <= next_rxState;
            rxShift <= next_rxShift;
            rxTicks <= next_rxTicks;
            rxLast  <= rxSync;
        end
    end

    //--------------------------------------------------------------
    // Status, flags and interrupt
    //--------------------------------------------------------------
    aspbg_pkg::aspbg_status_s next_status;
    logic                     next_irq;

    always_comb begin
        next_status = status;
        // Both frame kinds leave the byte in [7:0], the extra bit on top
        if (rxLoadOk) begin
            next_status.rxData     = rxShift[7:0];
            next_status.ninthRxBit = rxShift[8];
        end
        // Set beats a simultaneous clear so no event is lost
        if (txDoneClear) next_status.txDoneFlag = 1'b0;
        if (rxDoneClear) next_status.rxDoneFlag = 1'b0;
        if (txDoneSet)   next_status.txDoneFlag = 1'b1;
        if (rxDoneSet)   next_status.rxDoneFlag = 1'b1;
        next_irq = intEnable && (next_status.txDoneFlag ||
                                 next_status.rxDoneFlag);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= next_irq;
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    AST_IRQ_FOLLOWS_FLAGS: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        ##1 irq == (($past(intEnable) &&
                   (status.txDoneFlag || status.rxDoneFlag))))
        else $error("irq does not follow flags");
    AST_FLAG_STICKY: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        status.rxDoneFlag && !rxDoneClear |=> status.rxDoneFlag)
        else $error("rx done flag dropped without clear");
    AST_TX_START_BIT: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        dataWrite && txState == aspbg_pkg::ASPBG_TX_IDLE
        |=> !serialTxPin && txState == aspbg_pkg::ASPBG_TX_SHIFT)
        else $error("write did not start transmission");
    AST_TXDONE_AT_STOP: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        txDoneSet |=> serialTxPin && status.txDoneFlag)
        else $error("tx done not set at stop bit");
    AST_RX_RELOAD: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        rxStart |=> !rxOverflow)
        else $error("rx timer not reloaded at start");
    AST_NO_LOAD_WHEN_FULL: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        status.rxDoneFlag && !rxDoneClear |=> $stable(status.rxData))
        else $error("buffer overwritten while rx done set");
    AST_MP_FILTER: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        rxState == aspbg_pkg::ASPBG_RX_DONE && cfg.multiprocEnable &&
        !rxShift[8] |=> $stable(status.rxData))
        else $error("multiproc frame loaded with ninth bit low");
    AST_TX_BIT_HALF: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        txBitTick |-> !$past(txBitTick))
        else $error("bit tick on consecutive overflows");
    AST_START_IDLE: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        rxStart |-> cfg.rxEnable && $past(rxSync) && !rxSync)
        else $error("start without falling edge");
endmodule : aspbg_serial_port

// [sim/aspbg_remote_xcvr.sv]
// Behavioural far-end transceiver sitting on the serial pins
module aspbg_remote_xcvr #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic clk_sys,
    input  wire logic lineIn,
    output logic      lineOut
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line rests in mark state between frames
    initial lineOut = 1'h1;

    //--------------------------------------------------------------
    // Transmit one character toward the port
    //--------------------------------------------------------------
    task automatic sendFrame(input logic [7:0] d, input logic nine,
                             input logic useNinth);
        logic [10:0] bits;
        int          n;
        bits = useNinth ? {1'h1, nine, d, 1'h0} : {2'h3, d, 1'h0};
        n = useNinth ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            lineOut <= bits[i];
            repeat (BIT_CYCLES - 1) @(posedge clk_sys);
        end
    endtask : sendFrame

    //--------------------------------------------------------------
    // Capture one character from the port
    //--------------------------------------------------------------
    // The start bit may be shortened by the free-running timer phase, so
    // timing is taken from the rise into bit 0; data must have bit 0 set.
    task automatic recvFrame(input logic useNinth, output logic [7:0] d,
                             output logic nine, output logic stop);
        @(negedge lineIn);
        @(posedge lineIn);
        repeat (BIT_CYCLES / 2) @(posedge clk_sys);
        d[0] = lineIn;
        for (int i = 1; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_sys);
            d[i] = lineIn;
        end
        nine = 1'h0;
        if (useNinth) begin
            repeat (BIT_CYCLES) @(posedge clk_sys);
            nine = lineIn;
        end
        repeat (BIT_CYCLES) @(posedge clk_sys);
        stop = lineIn;
    endtask : recvFrame
endmodule : aspbg_remote_xcvr

// [sim/tb_async_serial_port_baud_gen.sv]
module tb_async_serial_port_baud_gen;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RELOAD = 8'hFC;
    localparam int         BITC   = 2 * (256 - 252);

    logic                     clk_sys, arst_n, intEnable, dataWrite;
    logic                     txDoneClear, rxDoneClear, extOscClock;
    logic                     timerExternalInput, farLine, serialTxPin, irq;
    logic [7:0]               dataWriteValue;
    logic [3:0]               extDiv;
    aspbg_pkg::aspbg_cfg_s    cfg;
    aspbg_pkg::aspbg_status_s status;
    int                       mismatches, total_checks;

    always #4 clk_sys = ~clk_sys;

    // Slow external clocks for the oscillator and pin sources
    always @(posedge clk_sys) begin
        extDiv <= extDiv + 4'h1;
        extOscClock <= extDiv[1];
        timerExternalInput <= extDiv[2];
    end

    aspbg_serial_port i_dut (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .cfg                (cfg),
        .intEnable          (intEnable),
        .dataWrite          (dataWrite),
        .dataWriteValue     (dataWriteValue),
        .txDoneClear        (txDoneClear),
        .rxDoneClear        (rxDoneClear),
        .extOscClock        (extOscClock),
        .timerExternalInput (timerExternalInput),
        .serialRxPin        (farLine),
        .serialTxPin        (serialTxPin),
        .status             (status),
        .irq                (irq)
    );

    aspbg_remote_xcvr #(.BIT_CYCLES(BITC)) i_far (
        .clk_sys (clk_sys),
        .lineIn  (serialTxPin),
        .lineOut (farLine)
    );

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    task automatic chkBit(input string name, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask : chkBit

    task automatic chkByte(input string name, input logic [7:0] e,
                           input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chkByte

    task automatic chkSpan(input string name, input int e, input int g);
        total_checks++;
        if (g < e - 1 || g > e + 1) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", name, e, g);
        end
    endtask : chkSpan

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle

    task automatic setCfg(input logic nine, mce, rxen, ninthTx,
                          input logic [2:0] src, input logic [7:0] rl);
        @(posedge clk_sys);
        cfg <= '{nine, mce, rxen, ninthTx, 1'h1, src, rl};
    endtask : setCfg

    task automatic writeData(input logic [7:0] v);
        @(posedge clk_sys);
        dataWrite <= 1'h1;
        dataWriteValue <= v;
        @(posedge clk_sys);
        dataWrite <= 1'h0;
    endtask : writeData

    task automatic pulse(input logic tx);
        @(posedge clk_sys);
        if (tx) txDoneClear <= 1'h1;
        else rxDoneClear <= 1'h1;
        @(posedge clk_sys);
        txDoneClear <= 1'h0;
        rxDoneClear <= 1'h0;
    endtask : pulse

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    task automatic testRx();
        setCfg(1'h0, 1'h0, 1'h0, 1'h0, 3'h0, RELOAD);
        i_far.sendFrame(8'h3C, 1'h0, 1'h0);
        idle(4);
        chkBit("rxDoneOff", 1'h0, status.rxDoneFlag);
        setCfg(1'h0, 1'h0, 1'h1, 1'h0, 3'h0, RELOAD);
        i_far.sendFrame(8'h3C, 1'h0, 1'h0);
        idle(4);
        chkBit("rxDoneFlag", 1'h1, status.rxDoneFlag);
        chkByte("rxData", 8'h3C, status.rxData);
        chkBit("ninthRxBit", 1'h1, status.ninthRxBit);
        chkBit("irq", 1'h1, irq);
        // Flag cleared while the next byte is still arriving
        fork
            i_far.sendFrame(8'hC3, 1'h0, 1'h0);
            begin
                idle(30);
                pulse(1'h0);
            end
        join
        idle(4);
        chkByte("rxData", 8'hC3, status.rxData);
        i_far.sendFrame(8'h5A, 1'h0, 1'h0);
        idle(40);
        chkByte("rxDataKept", 8'hC3, status.rxData);
        chkBit("rxDoneHeld", 1'h1, status.rxDoneFlag);
        pulse(1'h0);
        idle(3);
        chkBit("rxDoneClr", 1'h0, status.rxDoneFlag);
        chkBit("irqClr", 1'h0, irq);
    endtask : testRx

    task automatic testMulti();
        setCfg(1'h1, 1'h1, 1'h1, 1'h0, 3'h0, RELOAD);
        i_far.sendFrame(8'h11, 1'h0, 1'h1);
        idle(4);
        chkBit("rxDoneMce", 1'h0, status.rxDoneFlag);
        i_far.sendFrame(8'h22, 1'h1, 1'h1);
        idle(4);
        chkByte("rxDataMce", 8'h22, status.rxData);
        chkBit("ninthRxMce", 1'h1, status.ninthRxBit);
        intEnable <= 1'h0;
        idle(3);
        chkBit("irqMasked", 1'h0, irq);
        intEnable <= 1'h1;
        pulse(1'h0);
        setCfg(1'h1, 1'h0, 1'h1, 1'h0, 3'h0, RELOAD);
        i_far.sendFrame(8'h44, 1'h0, 1'h1);
        idle(4);
        chkByte("rxData9", 8'h44, status.rxData);
        chkBit("ninthRx9", 1'h0, status.ninthRxBit);
        pulse(1'h0);
    endtask : testMulti

    task automatic testTx(input logic nine, input logic nb,
                          input logic [7:0] v, input logic [7:0] rxKeep);
        logic [7:0] d;
        logic       n, s, prev;
        int         since;
        setCfg(nine, 1'h0, 1'h1, nb, 3'h0, RELOAD);
        fork
            i_far.recvFrame(nine, d, n, s);
            begin
                writeData(v);
                idle(20);
                writeData(8'hFF);
                since = 0;
                prev = serialTxPin;
                for (int i = 0; i < 200 && status.txDoneFlag !== 1'h1;
                     i++) begin
                    @(posedge clk_sys);
                    since = (serialTxPin && !prev) ? 0 : since + 1;
                    prev = serialTxPin;
                end
            end
        join
        chkByte("txData", v, d);
        if (nine) chkBit("ninthTx", nb, n);
        chkBit("stopBit", 1'h1, s);
        if (!nine) chkBit("txDoneAtStop", 1'h1, since <= 2);
        chkBit("txDoneHeld", 1'h1, status.txDoneFlag);
        chkBit("irqTx", 1'h1, irq);
        chkByte("rxUntouched", rxKeep, status.rxData);
        pulse(1'h1);
        idle(3);
        chkBit("txDoneClr", 1'h0, status.txDoneFlag);
        idle(BITC);
    endtask : testTx

    task automatic testRate();
        int  divs[6] = '{1, 4, 12, 48, 32, 8};
        int  e, t2, t3, ex;
        logic prev;
        for (int src = 0; src < 6; src++) begin
            setCfg(1'h0, 1'h0, 1'h1, 1'h0, src[2:0], 8'hFE);
            ex = 4 * (256 - 254) * divs[src];
            writeData(8'h55);
            e = 0;
            prev = serialTxPin;
            for (int c = 0; c < 4000 && e < 3; c++) begin
                @(posedge clk_sys);
                if (serialTxPin && !prev) e++;
                if (serialTxPin && !prev && e == 2) t2 = c;
                if (serialTxPin && !prev && e == 3) t3 = c;
                prev = serialTxPin;
            end
            chkSpan("twoBitCycles", ex, t3 - t2);
            for (int c = 0; c < 4000 && status.txDoneFlag !== 1'h1; c++)
                @(posedge clk_sys);
            pulse(1'h1);
            idle(ex);
        end
    endtask : testRate

    //--------------------------------------------------------------
    // Main sequence and watchdog
    //--------------------------------------------------------------
    initial begin
        clk_sys = 1'h0;
        arst_n = 1'h0;
        intEnable = 1'h1;
        dataWrite = 1'h0;
        dataWriteValue = 8'h00;
        txDoneClear = 1'h0;
        rxDoneClear = 1'h0;
        extDiv = 4'h0;
        extOscClock = 1'h0;
        timerExternalInput = 1'h0;
        cfg = '0;
        mismatches = 0;
        total_checks = 0;
        repeat (3) @(posedge clk_sys);
        chkBit("txIdleInReset", 1'h1, serialTxPin);
        chkBit("irqInReset", 1'h0, irq);
        arst_n <= 1'h1;
        testRx();
        testMulti();
        testTx(1'h0, 1'h0, 8'h25, 8'h44);
        testTx(1'h1, 1'h1, 8'h97, 8'h44);
        testRate();
        results();
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        results();
    end
endmodule : tb_async_serial_port_baud_gen
